/* File: ssp_defs.svh */
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH
// Contract
// - spi slave shifts only on serial clock pin edges; flag set on last bit
// - spi slave keeps working in sleep; a finished byte wakes the device
// - select-synchronised slave only when mode field is 0100
// - select low drives serial out; select high floats it at once; here it floats once the filtered select is high, after the pin filter
// - select high or port enable clear forces bit counter to zero
// - serial out pin set as input is never driven
// - spi master freezes in sleep and resumes where it stopped
// - slave shift register free of core timing; eighth bit sets flag; here it shifts on the core clock from the filtered pin
// - any reset disables the port and aborts the transfer
// - i2c start and stop detection reported to software
// - glitch filter on i2c clock and data inputs
// - mode picks i2c 7-bit, 10-bit slave or master at osc/(4*(addr+1))
// - status shows start, stop, data/address, update-address, direction
// - finished byte moves to transfer buffer and sets flag
// - byte finishing while buffer full sets overflow and is lost
// - 10-bit: high pattern matched first, then low byte after reload
// - i2c slave drives data line only when it must
// - matched address or data byte is acked and loaded automatically
// - no ack when buffer full or overflow already set
// - buffer full on arrival: buffer kept, flag and overflow set
// - buffer read clears buffer full; overflow cleared only by software
// - shift register moves data most significant bit first
// - overflow set, buffer empty: byte loads, flag set, no ack
`define OFF_GIC 8'h0b
`define OFF_PIR 8'h0c
`define OFF_XFER 8'h13
`define OFF_CTL 8'h14
`define OFF_PIE 8'h8c
`define OFF_OWN 8'h93
`define OFF_STS 8'h94
`define CTL_WCOL 7
`define CTL_OV 6
`define CTL_EN 5
`define CTL_CKP 4
`define STS_CKE 6
`define STS_DA 5
`define STS_P 4
`define STS_S 3
`define STS_RW 2
`define STS_UA 1
`define STS_BF 0
`define PIR_PORT 3
`define MODE_M4 4'h0
`define MODE_M16 4'h1
`define MODE_M64 4'h2
`define MODE_SS 4'h4
`define MODE_NOSS 4'h5
`define MODE_I7 4'h6
`define MODE_I10 4'h7
`define MODE_IM 4'h8
`define HALF_M4 9'h001
`define HALF_M16 9'h007
`define HALF_M64 9'h01f
`define RST_REG 8'h00
`define PIN_IDLE 5'h07
`endif

/* File: ssp_pkg.sv */
package ssp_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic sck;
    logic serial_in_pin;
    logic ss_n;
    logic scl;
    logic sda;
  } pins_t;

  typedef struct packed {
    pins_t s1;
    pins_t s2;
    pins_t s3;
    pins_t filt;
  } pin_sync_t;

  typedef enum logic [1:0] {
    I_IDLE = 2'b00,
    I_ADDR = 2'b01,
    I_ADDR2 = 2'b11,
    I_DATA = 2'b10
  } i2c_state_t;

  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] sts;
    logic [7:0] xfer;
    logic [7:0] own;
    logic [7:0] pir;
    logic [7:0] pie;
    logic [7:0] gic;
    logic [7:0] shreg;
    logic [3:0] bits;
    logic serial_out_pin;
    logic sck;
    logic scl;
    logic busy;
    logic ack;
    logic pend;
    logic [8:0] div;
    pins_t prev;
    i2c_state_t ist;
    logic [7:0] rdata;
  } core_t;
endpackage : ssp_pkg

/* File: pin_filter.sv */
`timescale 1ns/1ps
`include "ssp_defs.svh"
// three-stage pin synchroniser; a level counts once stages two and three agree
module pin_filter (
  input wire logic core_clk,
  input wire logic nrst,
  input wire ssp_pkg::pins_t raw,
  output ssp_pkg::pins_t filt
);
  ssp_pkg::pin_sync_t q, d;

  // short pulses seen by only one stage never reach filt
  always_comb
  begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < 5; i++)
    begin
      if (q.s2[i] == q.s3[i])
      begin
        d.filt[i] = q.s3[i];
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= {`PIN_IDLE, `PIN_IDLE, `PIN_IDLE, `PIN_IDLE};
    end
    else
    begin
      q <= d;
    end
  end

  assign filt = q.filt;

  glitch_block_a: assert property (@(posedge core_clk) disable iff (!nrst)
    1'b1 |-> ((q.filt ^ $past(q.filt))
      & (($past(q.s2) ^ $past(q.s3)) | (q.filt ^ $past(q.s3)))) == 5'h00)
    else $error("filtered pin moved without agreement");
endmodule : pin_filter

/* File: ssp_core.sv */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`include "ssp_defs.svh"
// serial port: spi master/slave and i2c slave receive, register bus on a plain port
module ssp_core (
  input wire logic core_clk,
  input wire logic nrst,
  input wire ssp_pkg::bus_req_t bus,
  output logic [7:0] rdata,
  input wire ssp_pkg::pins_t pins,
  input wire logic sdo_tris,
  input wire logic sleep,
  output logic sdo_out,
  output logic sdo_oe_n,
  output logic sck_out,
  output logic sck_oe_n,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  output logic wake
);
  ssp_pkg::core_t q, d;
  ssp_pkg::pins_t pf;
  logic en, spi_m, spi_s, i2c_s, i2c_m, ss_hold, tick, edge_v, lvl, done;
  logic [3:0] mode;
  logic [7:0] rx;

  // half period of the generated clock, in core cycles minus one
  function automatic logic [8:0] half_lim(input logic [3:0] m, input logic [7:0] own);
    logic [8:0] r;
    r = {own, 1'b1}; // osc/(4*(own+1))
    unique case (m)
      `MODE_M4: r = `HALF_M4;
      `MODE_M16: r = `HALF_M16;
      `MODE_M64: r = `HALF_M64;
      default: r = {own, 1'b1};
    endcase
    return r;
  endfunction : half_lim

  // pins are sampled into the core clock before any status is derived
  pin_filter u_filt (
    .core_clk(core_clk),
    .nrst(nrst),
    .raw(pins),
    .filt(pf)
  );

  // mode decode
  always_comb
  begin
    en = q.ctl[`CTL_EN];
    mode = q.ctl[3:0];
    spi_m = en && (mode == `MODE_M4 || mode == `MODE_M16 || mode == `MODE_M64);
    spi_s = en && (mode == `MODE_SS || mode == `MODE_NOSS);
    i2c_s = en && (mode == `MODE_I7 || mode == `MODE_I10);
    i2c_m = en && mode == `MODE_IM;
    ss_hold = spi_s && mode == `MODE_SS && pf.ss_n;
    tick = (spi_m || i2c_m) && !sleep && q.div == half_lim(mode, q.own);
  end

  // all next-state logic: bus first, hardware events after so sets win
  always_comb
  begin
    d = q;
    edge_v = 1'b0;
    lvl = 1'b0;
    done = 1'b0;
    rx = q.shreg;
    d.prev = pf;
    d.rdata = 8'h00;
    // register reads; data stands only in the following cycle
    if (bus.rd)
    begin
      unique case (bus.addr)
        `OFF_GIC: d.rdata = q.gic;
        `OFF_PIR: d.rdata = q.pir;
        `OFF_XFER: d.rdata = q.xfer;
        `OFF_CTL: d.rdata = q.ctl;
        `OFF_PIE: d.rdata = q.pie;
        `OFF_OWN: d.rdata = q.own;
        `OFF_STS: d.rdata = q.sts;
        default: d.rdata = 8'h00;
      endcase
      if (bus.addr == `OFF_XFER)
      begin
        d.sts[`STS_BF] = 1'b0;
      end
    end
    if (bus.wr)
    begin
      unique case (bus.addr)
        `OFF_GIC: d.gic = bus.wdata;
        `OFF_PIR: d.pir = bus.wdata;
        `OFF_CTL: d.ctl = bus.wdata; // overflow cleared here only
        `OFF_PIE: d.pie = bus.wdata;
        `OFF_STS: d.sts[7:6] = bus.wdata[7:6];
        `OFF_OWN:
        begin
          d.own = bus.wdata;
          d.sts[`STS_UA] = 1'b0;
        end
        `OFF_XFER:
        begin
          // a write in mid-byte would corrupt the shifter, so it is refused
          if (q.bits != 4'h0 || q.busy)
          begin
            d.ctl[`CTL_WCOL] = 1'b1;
          end
          else
          begin
            d.xfer = bus.wdata;
            d.shreg = bus.wdata;
            d.serial_out_pin = bus.wdata[7];
            d.busy = spi_m;
          end
        end
        default: d.bits = q.bits;
      endcase
    end
    // clock generator for spi master and i2c master
    if (tick)
    begin
      d.div = 9'h000;
    end
    else if ((spi_m || i2c_m) && !sleep)
    begin
      d.div = q.div + 9'h001;
    end
    if (i2c_m && tick)
    begin
      d.scl = !q.scl;
    end
    // spi edges: own clock in master mode, filtered pin in slave mode
    if (spi_m)
    begin
      edge_v = tick && q.busy;
      lvl = !q.sck;
      if (edge_v)
      begin
        d.sck = lvl;
      end
      else if (!q.busy)
      begin
        d.sck = q.ctl[`CTL_CKP];
      end
    end
    else if (spi_s && !ss_hold)
    begin
      edge_v = pf.sck != q.prev.sck;
      lvl = pf.sck;
    end
    if (edge_v)
    begin
      if (lvl == (q.ctl[`CTL_CKP] ^ q.sts[`STS_CKE]))
      begin
        rx = {q.shreg[6:0], pf.serial_in_pin};
        d.shreg = rx;
        d.bits = q.bits + 4'h1;
        if (q.bits == 4'h7)
        begin
          d.bits = 4'h0;
          d.busy = 1'b0;
          done = 1'b1;
        end
      end
      else
      begin
        d.serial_out_pin = q.shreg[7];
      end
    end
    if (!en || ss_hold)
    begin
      d.bits = 4'h0;
      d.busy = 1'b0;
    end
    // spi byte end: buffer and flags
    if (done)
    begin
      d.pir[`PIR_PORT] = 1'b1;
      if (q.sts[`STS_BF])
      begin
        d.ctl[`CTL_OV] = 1'b1;
      end
      else
      begin
        d.xfer = rx;
        d.sts[`STS_BF] = 1'b1;
      end
    end
    // i2c slave receive
    if (i2c_s)
    begin
      if (q.prev.scl && pf.scl && q.prev.sda && !pf.sda)
      begin
        d.ist = ssp_pkg::I_ADDR;
        d.bits = 4'h0;
        d.ack = 1'b0;
        d.pend = 1'b0;
        d.sts[`STS_S] = 1'b1;
        d.sts[`STS_P] = 1'b0;
      end
      else if (q.prev.scl && pf.scl && !q.prev.sda && pf.sda)
      begin
        d.ist = ssp_pkg::I_IDLE;
        d.ack = 1'b0;
        d.sts[`STS_P] = 1'b1;
        d.sts[`STS_S] = 1'b0;
      end
      else if (!q.prev.scl && pf.scl && q.ist != ssp_pkg::I_IDLE && q.bits < 4'h8)
      begin
        d.shreg = {q.shreg[6:0], pf.sda};
        d.bits = q.bits + 4'h1;
      end
      else if (q.prev.scl && !pf.scl && q.bits == 4'h9)
      begin
        d.ack = 1'b0;
        d.bits = 4'h0;
        if (q.pend)
        begin
          d.pir[`PIR_PORT] = 1'b1;
        end
        d.pend = 1'b0;
      end
      else if (q.prev.scl && !pf.scl && q.bits == 4'h8)
      begin
        d.bits = 4'h9;
        d.pend = 1'b1;
        unique case (q.ist)
          ssp_pkg::I_ADDR:
          begin
            d.sts[`STS_DA] = 1'b0;
            d.sts[`STS_RW] = q.shreg[0];
            if (q.shreg[7:1] != q.own[7:1])
            begin
              d.pend = 1'b0;
              d.ist = ssp_pkg::I_IDLE;
            end
            else if (mode == `MODE_I10)
            begin
              d.sts[`STS_UA] = 1'b1;
              d.ist = ssp_pkg::I_ADDR2;
            end
            else
            begin
              d.ist = ssp_pkg::I_DATA;
            end
          end
          ssp_pkg::I_ADDR2:
          begin
            d.sts[`STS_DA] = 1'b0;
            if (q.shreg != q.own)
            begin
              d.pend = 1'b0;
              d.ist = ssp_pkg::I_IDLE;
            end
            else
            begin
              d.sts[`STS_UA] = 1'b1;
              d.ist = ssp_pkg::I_DATA;
            end
          end
          ssp_pkg::I_DATA: d.sts[`STS_DA] = 1'b1;
          default: d.pend = 1'b0;
        endcase
        if (d.pend)
        begin
          d.ack = !q.sts[`STS_BF] && !q.ctl[`CTL_OV];
          if (q.sts[`STS_BF])
          begin
            d.ctl[`CTL_OV] = 1'b1;
          end
          else
          begin
            d.xfer = q.shreg;
            d.sts[`STS_BF] = 1'b1;
          end
        end
      end
    end
    else
    begin
      d.ist = ssp_pkg::I_IDLE;
      d.ack = 1'b0;
      d.pend = 1'b0;
      if (!spi_s && !spi_m)
      begin
        d.bits = 4'h0;
      end
    end
  end

  // any reset clears control, so the port comes up disabled
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.ctl <= `RST_REG;
      q.prev <= `PIN_IDLE;
      q.scl <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  // pins; enables are active low
  always_comb
  begin
    rdata = q.rdata;
    sdo_out = q.serial_out_pin;
    sdo_oe_n = !((spi_s || spi_m) && !sdo_tris && !ss_hold);
    sck_out = q.sck;
    sck_oe_n = !spi_m;
    scl_out = q.scl;
    scl_oe_n = !(i2c_m && !q.scl);
    sda_out = 1'b0;
    sda_oe_n = !q.ack;
    wake = q.pir[`PIR_PORT] && q.pie[`PIR_PORT];
  end

  ss_release_a: assert property (@(posedge core_clk) disable iff (!nrst)
    ss_hold |-> sdo_oe_n)
    else $error("serial out driven while deselected");

  out_tris_a: assert property (@(posedge core_clk) disable iff (!nrst)
    sdo_tris |-> sdo_oe_n)
    else $error("serial out driven while set as input");

  bit_clear_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (!en || ss_hold) |=> q.bits == 4'h0 || i2c_s)
    else $error("bit counter not cleared");

  sleep_freeze_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (spi_m && sleep && !bus.wr) |=> $stable(q.bits) && $stable(q.sck))
    else $error("master moved during sleep");

  buf_read_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (bus.rd && bus.addr == `OFF_XFER && !done && !(d.pend && !q.pend))
      |=> !q.sts[`STS_BF])
    else $error("buffer read left buffer full set");

  full_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (done && q.sts[`STS_BF]) |=> q.ctl[`CTL_OV] && q.pir[`PIR_PORT] && $stable(q.xfer))
    else $error("overflow byte not discarded");

  no_ack_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (i2c_s && q.bits == 4'h8 && (q.sts[`STS_BF] || q.ctl[`CTL_OV])) |=> !q.ack)
    else $error("ack given while overflow or full");

  wake_flag_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (done && q.pie[`PIR_PORT]) |=> wake)
    else $error("finished byte did not wake");

  spi_load_a: assert property (@(posedge core_clk) disable iff (!nrst)
    (done && !q.sts[`STS_BF]) |=> q.sts[`STS_BF] && q.xfer == $past(rx))
    else $error("received byte not moved to buffer");
endmodule : ssp_core

/* File: spi_master_model.sv */
`timescale 1ns/1ps
// far side of the port: an spi master clocking the slave, plus i2c line control
module spi_master_model (
  input wire logic core_clk,
  input wire logic sdo_out,
  input wire logic sdo_oe_n,
  output ssp_pkg::pins_t pins
);
  // half bit time; longer than the pin filter latency so every level is seen
  localparam int HALF = 8;

  // idle: clock low and still, select high, i2c lines pulled high
  initial pins = 5'b00111;

  // msb first (ckp=0, cke=0): data moves with the rising edge, the slave samples on the fall;
  // sdi is held across the fall so the filtered clock and data never change together there
  task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      pins.sck <= 1'b1;
      pins.serial_in_pin <= tx[i];
      repeat (HALF) @(posedge core_clk);
      rx[i] = sdo_oe_n ? 1'bx : sdo_out; // a floating line never reads as data
      pins.sck <= 1'b0;
      repeat (HALF) @(posedge core_clk);
    end
    pins.serial_in_pin <= ~tx[8 - n]; // released line shows the inverse, not the last bit
    @(posedge core_clk);
  endtask : shift

  // select level, held long enough to pass the filter
  task automatic sel(input logic lvl);
    pins.ss_n <= lvl;
    repeat (HALF) @(posedge core_clk);
  endtask : sel

  // i2c line levels for start, stop and glitch stimulus
  task automatic i2c(input logic scl, input logic sda, input int cyc);
    pins.scl <= scl;
    pins.sda <= sda;
    repeat (cyc) @(posedge core_clk);
  endtask : i2c
endmodule : spi_master_model

/* File: testbench.sv */
`timescale 1ns/1ps
`include "ssp_defs.svh"
module testbench;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  ssp_pkg::bus_req_t bus = '0;
  logic sleep = 1'b0;
  logic sdo_tris = 1'b0;
  ssp_pkg::pins_t pins;
  logic [7:0] rdata;
  logic sdo_out;
  logic sdo_oe_n;
  logic wake;
  logic sck_oe_n;
  logic sda_oe_n;
  logic oe;
  logic [7:0] d;
  logic [7:0] rx;
  int error_cnt = 0;
  int compares = 0;

  // 20 mhz core clock
  always #25 core_clk = ~core_clk;

  spi_master_model partner (.core_clk(core_clk), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .pins(pins));

  ssp_core dut (.core_clk(core_clk), .nrst(nrst), .bus(bus), .rdata(rdata), .pins(pins),
    .sdo_tris(sdo_tris), .sleep(sleep), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n),
    .sck_out(), .sck_oe_n(sck_oe_n), .scl_out(), .scl_oe_n(), .sda_out(), .sda_oe_n(sda_oe_n),
    .wake(wake));

  // byte compare; case inequality so an unknown never matches
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one-cycle write strobe, then a quiet cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus <= '0;
    @(posedge core_clk);
  endtask : wr

  // read data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus <= '0;
    @(negedge core_clk);
    v = rdata;
    @(posedge core_clk);
  endtask : rd

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    rd(a, d);
    chk(d, exp);
  endtask : rdchk

  // bounded wait for the wake level
  task automatic wait_wake;
    int n;
    n = 0;
    while (wake !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    chk({7'h00, wake}, 8'h01);
  endtask : wait_wake

  // one i2c byte, msb first, plus the ninth clock; returns the ack enable seen on the fall after the 8th rise
  task automatic i2c_byte(input logic [7:0] b, output logic oe_n);
    for (int i = 7; i >= 0; i--)
    begin
      partner.i2c(1'b0, b[i], 8);
      partner.i2c(1'b1, b[i], 8);
    end
    partner.i2c(1'b0, 1'b1, 8);
    oe_n = sda_oe_n;
    partner.i2c(1'b1, 1'b1, 8);
    partner.i2c(1'b0, 1'b1, 8);
  endtask : i2c_byte

  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // watchdog against a hung run
  initial
  begin
    repeat (60000) @(posedge core_clk);
    error_cnt++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rdchk(`OFF_CTL, 8'h00);
    rdchk(`OFF_STS, 8'h00);
    rdchk(`OFF_PIR, 8'h00);
    rdchk(`OFF_PIE, 8'h00);
    rdchk(8'h55, 8'h00);
    // selected slave receiving while asleep
    wr(`OFF_PIE, 8'h08);
    wr(`OFF_CTL, 8'h24); // cke stays 0; cke=1 would need mode 0100
    wr(`OFF_XFER, 8'ha5);
    partner.sel(1'b0);
    chk({7'h00, sdo_oe_n}, 8'h00);
    sleep <= 1'b1;
    partner.shift(8'h3c, 8, rx);
    wait_wake();
    sleep <= 1'b0;
    chk(rx, 8'ha5);
    rdchk(`OFF_PIR, 8'h08);
    rdchk(`OFF_STS, 8'h01);
    rdchk(`OFF_XFER, 8'h3c);
    rdchk(`OFF_STS, 8'h00);
    wr(`OFF_PIR, 8'h00);
    // second byte lands on a full buffer
    partner.shift(8'h81, 8, rx);
    partner.shift(8'h7e, 8, rx);
    rdchk(`OFF_CTL, 8'h64);
    rdchk(`OFF_XFER, 8'h81);
    rdchk(`OFF_CTL, 8'h64);
    wr(`OFF_CTL, 8'h24);
    rdchk(`OFF_CTL, 8'h24);
    // buffer write mid-byte refused, then deselect mid-byte
    partner.shift(8'hf0, 4, rx);
    wr(`OFF_XFER, 8'h11);
    rdchk(`OFF_CTL, 8'ha4);
    wr(`OFF_CTL, 8'h24);
    partner.sel(1'b1);
    chk({7'h00, sdo_oe_n}, 8'h01);
    partner.sel(1'b0);
    partner.shift(8'h5a, 8, rx);
    rdchk(`OFF_XFER, 8'h5a);
    // clock edges while deselected are ignored
    partner.sel(1'b1);
    partner.shift(8'h33, 8, rx);
    rdchk(`OFF_STS, 8'h00);
    // port disabled mid-byte restarts the count
    partner.sel(1'b0);
    partner.shift(8'hff, 4, rx);
    wr(`OFF_CTL, 8'h04);
    wr(`OFF_CTL, 8'h24);
    partner.shift(8'hc3, 8, rx);
    rdchk(`OFF_XFER, 8'hc3);
    // slave without select, output pin as input: receive only
    partner.sel(1'b1);
    wr(`OFF_CTL, 8'h25);
    sdo_tris <= 1'b1;
    partner.shift(8'h96, 8, rx);
    chk({7'h00, sdo_oe_n}, 8'h01);
    rdchk(`OFF_XFER, 8'h96);
    sdo_tris <= 1'b0;
    // reset in mid-byte
    partner.shift(8'h0f, 4, rx);
    nrst <= 1'b0;
    @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    rdchk(`OFF_CTL, 8'h00);
    rdchk(`OFF_STS, 8'h00);
    // spi master: the byte freezes while asleep and finishes after waking; sdi idles high
    wr(`OFF_CTL, 8'h20);
    wr(`OFF_XFER, 8'h3c);
    chk({7'h00, sck_oe_n}, 8'h00);
    sleep <= 1'b1;
    repeat (40) @(posedge core_clk);
    rdchk(`OFF_STS, 8'h00);
    sleep <= 1'b0;
    repeat (40) @(posedge core_clk);
    rdchk(`OFF_STS, 8'h01);
    rdchk(`OFF_XFER, 8'hff);
    // i2c slave: a one-cycle dip is filtered, real start and stop are seen
    wr(`OFF_CTL, 8'h26);
    partner.i2c(1'b1, 1'b0, 1);
    partner.i2c(1'b1, 1'b1, 8);
    rd(`OFF_STS, d);
    chk(d & 8'h18, 8'h00);
    partner.i2c(1'b1, 1'b0, 8);
    rd(`OFF_STS, d);
    chk(d & 8'h18, 8'h08);
    partner.i2c(1'b0, 1'b0, 8);
    partner.i2c(1'b1, 1'b0, 8);
    partner.i2c(1'b1, 1'b1, 8);
    rd(`OFF_STS, d);
    chk(d & 8'h10, 8'h10);
    // matched address is loaded and acked; a data byte on the full buffer is refused
    wr(`OFF_OWN, 8'ha0);
    wr(`OFF_PIR, 8'h00);
    partner.i2c(1'b1, 1'b0, 8);
    i2c_byte(8'ha0, oe);
    chk({7'h00, oe}, 8'h00);
    rdchk(`OFF_PIR, 8'h08);
    rdchk(`OFF_STS, 8'h09);
    i2c_byte(8'h5c, oe);
    chk({7'h00, oe}, 8'h01);
    rdchk(`OFF_CTL, 8'h66);
    rdchk(`OFF_XFER, 8'ha0);
    wrap_up();
  end
endmodule : testbench
